// File: inc/pcbr_pkg.sv
/*
  Constants for the power-control, backup and RTC-time register bank.
  Assumes a 250 MHz ref_clk and 32-bit AHB-Lite access, one register per word.
*/
package pcbr_pkg;

  // ---------------------------------------------------------------
  // Register indices and byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_POWER_CUT_LIMITS     = 8'h0e;
  localparam logic [7:0] IDX_RESET_SOURCE_CONTROL = 8'h0f;
  localparam logic [7:0] IDX_UNUSED_SIXTEEN       = 8'h10;
  localparam logic [7:0] IDX_UNUSED_SEVENTEEN     = 8'h11;
  localparam logic [7:0] IDX_BACKUP_WORD_A        = 8'h12;
  localparam logic [7:0] IDX_BACKUP_WORD_B        = 8'h13;
  localparam logic [7:0] IDX_RTC_TIME_WORD        = 8'h14;
  localparam logic [7:0] IDX_GLOBAL_RESET_CONTROL = 8'h20;
  localparam logic [9:0] ADDR_SCALE               = 10'h004;

  // ---------------------------------------------------------------
  // Writable-bit masks and reset values
  // ---------------------------------------------------------------
  localparam logic [23:0] PCL_MASK      = 24'h00ffff;
  localparam logic [23:0] RSC_MASK      = 24'hc67fff;
  localparam logic [23:0] RSC_RESET     = 24'h400000;
  localparam logic [23:0] RSC_SYS_MASK  = 24'hc01000;
  localparam logic [23:0] RTC_MASK      = 24'h3fffff;
  localparam logic [23:0] WORD_MASK     = 24'hffffff;
  localparam logic [23:0] ZERO_WORD     = 24'h000000;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int POS_CUT_TIMER      = 0;
  localparam int POS_CUT_COUNT      = 8;
  localparam int POS_CUT_LIMIT      = 12;
  localparam int POS_RESTART        = 0;
  localparam int POS_BTN_RST_EN     = 1;
  localparam int POS_BTN_DBNC       = 4;
  localparam int POS_STBY_INV       = 10;
  localparam int POS_STBY_SEC_INV   = 11;
  localparam int POS_WDOG_EN        = 12;
  localparam int POS_STBY_DELAY     = 22;
  localparam int POS_TOD            = 0;
  localparam int POS_RTC_CAL        = 17;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 250;

endpackage : pcbr_pkg

// File: hw/pcbr_regs.sv
/*
  Power-control register bank: power-cut limits, reset sources with
  debounced power buttons, standby polarity, watchdog reset, global reset,
  battery-backed words and the RTC time word, reached over AHB-Lite.
  Assumes reset is the RTC power-on reset and system_reset_n a pin.
*/
// Added by the designer: the AHB-Lite register port.
// Notes on behaviour
// RQ1: Power-cut word holds timer 7:0, count 11:8, limit 15:12.
// RQ2: Auto-restart bit requests power-up when a system reset ends.
// RQ3: Three button enable bits let each button raise system reset.
// RQ4: Each button has its own 2-bit debounce time select.
// RQ5: Bit 10 makes the primary standby input active low.
// RQ6: Bit 11 makes the secondary standby input active low.
// RQ7: Bit 12 lets the watchdog input reset; system reset clears it.
// RQ8: Global reset polarity bit default follows the variant parameter.
// RQ9: RTC word holds writable 17-bit time and 5-bit calibration.
// RQ10: Backup words survive system reset; unused bits read zero.
module pcbr_regs
  import pcbr_pkg::*;
#(
  parameter logic        GLOBAL_RESET_HIGH = 1'b0,
  parameter int unsigned DEBOUNCE_US_0     = 0,
  parameter int unsigned DEBOUNCE_US_1     = 30000,
  parameter int unsigned DEBOUNCE_US_2     = 60000,
  parameter int unsigned DEBOUNCE_US_3     = 120000
) (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        system_reset_n,
  input  wire logic        power_button_one,
  input  wire logic        power_button_two,
  input  wire logic        power_button_three,
  input  wire logic        standby_in,
  input  wire logic        secondary_standby_in,
  input  wire logic        watchdog_input,
  output logic             system_reset_request,
  output logic             power_up_request,
  output logic             standby_active,
  output logic             secondary_standby_active,
  output logic             global_reset_active,
  output logic [2:0]       button_pressed,
  output logic [1:0]       standby_delay_sel,
  output logic [7:0]       power_cut_timer,
  output logic [3:0]       power_cut_count,
  output logic [3:0]       power_cut_limit
);

  // ---------------------------------------------------------------
  // Debounce cycle counts
  // ---------------------------------------------------------------
  localparam logic [31:0] DBNC_CYC_0 = 32'(DEBOUNCE_US_0 * CLK_MHZ);
  localparam logic [31:0] DBNC_CYC_1 = 32'(DEBOUNCE_US_1 * CLK_MHZ);
  localparam logic [31:0] DBNC_CYC_2 = 32'(DEBOUNCE_US_2 * CLK_MHZ);
  localparam logic [31:0] DBNC_CYC_3 = 32'(DEBOUNCE_US_3 * CLK_MHZ);

  // Debounce length for a 2-bit select; each button passes its own
  function automatic logic [31:0] dbnc_cycles(input logic [1:0] sel);
    logic [31:0] c;
    c = DBNC_CYC_0;
    if (sel == 2'h1) begin
      c = DBNC_CYC_1;
    end else if (sel == 2'h2) begin
      c = DBNC_CYC_2;
    end else if (sel == 2'h3) begin
      c = DBNC_CYC_3;
    end
    return c;
  endfunction : dbnc_cycles

  // Byte address of a register index
  function automatic logic [7:0] reg_addr(input logic [7:0] idx);
    return 8'(idx * ADDR_SCALE);
  endfunction : reg_addr

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [23:0] power_cut_limits;
  logic [23:0] reset_source_control;
  logic [23:0] backup_word_a;
  logic [23:0] backup_word_b;
  logic [23:0] rtc_time_word;
  logic        global_reset_polarity;

  // Bus state
  logic        wr_pend;
  logic        rd_pend;
  logic [7:0]  addr_q;

  // Pin synchronisers: three stages, change taken when 2nd and 3rd agree
  logic [6:0]  pin_s1;
  logic [6:0]  pin_s2;
  logic [6:0]  pin_s3;
  logic [6:0]  pin_lvl;
  logic        sys_rst_prev;

  // Button debounce
  logic [2:0]  btn_db;
  logic [31:0] btn_cnt [3];

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire logic        bus_take  = hsel & hready & htrans[1];
  wire logic        take_wr   = bus_take & hwrite;
  wire logic        take_rd   = bus_take & ~hwrite;
  wire logic        sys_rst   = ~pin_lvl[0];
  wire logic [6:0]  pin_raw   = {watchdog_input, secondary_standby_in, standby_in,
                                 power_button_three, power_button_two,
                                 power_button_one, system_reset_n};
  wire logic [23:0] wdata     = hwdata[23:0];
  wire logic        hit_pcl   = (addr_q == reg_addr(IDX_POWER_CUT_LIMITS));
  wire logic        hit_rsc   = (addr_q == reg_addr(IDX_RESET_SOURCE_CONTROL));
  wire logic        hit_backup_word_a_bits  = (addr_q == reg_addr(IDX_BACKUP_WORD_A));
  wire logic        hit_backup_word_b_bits  = (addr_q == reg_addr(IDX_BACKUP_WORD_B));
  wire logic        hit_rtc   = (addr_q == reg_addr(IDX_RTC_TIME_WORD));
  wire logic        hit_glb   = (addr_q == reg_addr(IDX_GLOBAL_RESET_CONTROL));
  wire logic [1:0]  dbnc_sel [3];
  wire logic [2:0]  btn_rst_en;
  wire logic        wdog_en;
  wire logic        stby_inv;
  wire logic        stby_sec_inv;
  wire logic        restart_en;
  wire logic [23:0] rd_word;

  // Field extraction
  assign dbnc_sel[0]  = reset_source_control[POS_BTN_DBNC +: 2];     // RQ4
  assign dbnc_sel[1]  = reset_source_control[POS_BTN_DBNC + 2 +: 2]; // RQ4
  assign dbnc_sel[2]  = reset_source_control[POS_BTN_DBNC + 4 +: 2]; // RQ4
  assign btn_rst_en   = reset_source_control[POS_BTN_RST_EN +: 3];
  assign wdog_en      = reset_source_control[POS_WDOG_EN];
  assign stby_inv     = reset_source_control[POS_STBY_INV];
  assign stby_sec_inv = reset_source_control[POS_STBY_SEC_INV];
  assign restart_en   = reset_source_control[POS_RESTART];

  // Read mux; reserved and unmapped words read as zero
  assign rd_word = hit_pcl  ? power_cut_limits :
                   hit_rsc  ? reset_source_control :
                   hit_backup_word_a_bits ? backup_word_a :
                   hit_backup_word_b_bits ? backup_word_b :
                   hit_rtc  ? rtc_time_word :
                   hit_glb  ? {23'h0, global_reset_polarity} :
                   ZERO_WORD; // RQ10

  // ---------------------------------------------------------------
  // AHB-Lite slave
  // ---------------------------------------------------------------
  // Reads take one wait state so a write just before is always seen
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wr_pend   <= 1'b0;
      rd_pend   <= 1'b0;
      addr_q    <= 8'h00;
      hreadyout <= 1'b1;
      hrdata    <= 32'h00000000;
      hresp     <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (rd_pend) begin
        rd_pend   <= 1'b0;
        hreadyout <= 1'b1;
        hrdata    <= {8'h00, rd_word};
      end else begin
        wr_pend <= take_wr;
        rd_pend <= take_rd;
        if (bus_take) begin
          addr_q <= haddr[7:0];
        end
        if (take_rd) begin
          hreadyout <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers reset by the RTC power-on reset only
  // ---------------------------------------------------------------
  // Backup and time words keep their value across system resets
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      power_cut_limits      <= ZERO_WORD;
      backup_word_a         <= ZERO_WORD;
      backup_word_b         <= ZERO_WORD;
      rtc_time_word         <= ZERO_WORD;
      global_reset_polarity <= GLOBAL_RESET_HIGH; // RQ8
    end else if (wr_pend) begin
      if (hit_pcl) begin
        power_cut_limits <= wdata & PCL_MASK; // RQ1
      end
      if (hit_backup_word_a_bits) begin
        backup_word_a <= wdata & WORD_MASK; // RQ10
      end
      if (hit_backup_word_b_bits) begin
        backup_word_b <= wdata & WORD_MASK; // RQ10
      end
      if (hit_rtc) begin
        rtc_time_word <= wdata & RTC_MASK; // RQ9
      end
      if (hit_glb) begin
        global_reset_polarity <= wdata[0]; // RQ8
      end
    end
  end

  // ---------------------------------------------------------------
  // Reset-source control: some fields also reset by system reset (watchdog enable cleared, standby delay back to 1)
  // ---------------------------------------------------------------
  // A write during system reset still lands in the RTC-domain fields
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      reset_source_control <= RSC_RESET;
    end else if (wr_pend && hit_rsc) begin
      reset_source_control <= sys_rst ?
        (((wdata & RSC_MASK) & ~RSC_SYS_MASK) | RSC_RESET) : (wdata & RSC_MASK);
    end else if (sys_rst) begin
      reset_source_control <= (reset_source_control & ~RSC_SYS_MASK) | RSC_RESET; // RQ7
    end
  end

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // Pins idle high: buttons and resets are active low at the pin
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pin_s1  <= 7'h7f;
      pin_s2  <= 7'h7f;
      pin_s3  <= 7'h7f;
      pin_lvl <= 7'h7f;
    end else begin
      pin_s1  <= pin_raw;
      pin_s2  <= pin_s1;
      pin_s3  <= pin_s2;
      pin_lvl <= (pin_s2 & pin_s3) | (pin_lvl & (pin_s2 ^ pin_s3));
    end
  end

  // ---------------------------------------------------------------
  // Button debounce
  // ---------------------------------------------------------------
  // A level must hold for the selected time before it is accepted
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      btn_db <= 3'h7;
      for (int i = 0; i < 3; i++) begin
        btn_cnt[i] <= 32'h00000000;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (pin_lvl[i + 1] == btn_db[i]) begin
          btn_cnt[i] <= 32'h00000000;
        end else if (btn_cnt[i] >= dbnc_cycles(dbnc_sel[i])) begin // RQ4
          btn_db[i]  <= pin_lvl[i + 1];
          btn_cnt[i] <= 32'h00000000;
        end else begin
          btn_cnt[i] <= btn_cnt[i] + 32'h00000001;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  wire logic next_system_reset_request = (|(~btn_db & btn_rst_en)) // RQ3
                                        | (wdog_en & ~pin_lvl[6]);  // RQ7
  wire logic next_power_up_request     = restart_en & sys_rst_prev & ~sys_rst; // RQ2
  wire logic next_global_reset_active  = (btn_db[2] == global_reset_polarity); // RQ8

  // All outputs registered
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      system_reset_request     <= 1'b0;
      power_up_request         <= 1'b0;
      standby_active           <= 1'b0;
      secondary_standby_active <= 1'b0;
      global_reset_active      <= 1'b0;
      button_pressed           <= 3'h0;
      standby_delay_sel        <= 2'h1;
      power_cut_timer          <= 8'h00;
      power_cut_count          <= 4'h0;
      power_cut_limit          <= 4'h0;
      sys_rst_prev             <= 1'b0;
    end else begin
      sys_rst_prev             <= sys_rst;
      system_reset_request     <= next_system_reset_request;
      power_up_request         <= next_power_up_request;
      standby_active           <= pin_lvl[4] ^ stby_inv;     // RQ5
      secondary_standby_active <= pin_lvl[5] ^ stby_sec_inv; // RQ6
      global_reset_active      <= next_global_reset_active;
      button_pressed           <= ~btn_db;
      standby_delay_sel        <= reset_source_control[POS_STBY_DELAY +: 2];
      power_cut_timer          <= power_cut_limits[POS_CUT_TIMER +: 8]; // RQ1
      power_cut_count          <= power_cut_limits[POS_CUT_COUNT +: 4]; // RQ1
      power_cut_limit          <= power_cut_limits[POS_CUT_LIMIT +: 4]; // RQ1
    end
  end

endmodule : pcbr_regs

// File: tb/pcbr_regs_asserts.sv
/*
  Checker for the power-control register bank: bus handshake and pin rules.
  Assumes it is bound to the top module and sees only its ports.
*/
module pcbr_regs_asserts (
  input wire logic        ref_clk, reset, hsel, hwrite, hready, hreadyout, hresp,
  input wire logic [1:0]  htrans,
  input wire logic [31:0] hrdata,
  input wire logic        system_reset_n, watchdog_input, power_up_request,
  input wire logic        power_button_one, power_button_two, power_button_three,
  input wire logic        standby_in, secondary_standby_in, system_reset_request,
  input wire logic        standby_active, secondary_standby_active,
  input wire logic [2:0]  button_pressed,
  input wire logic [7:0]  power_cut_timer,
  input wire logic [3:0]  power_cut_count, power_cut_limit
);
  timeunit 1ns;
  timeprecision 100ps;

  // -----------------------------------------------------------------
  // Helper counters
  // -----------------------------------------------------------------
  logic       acc;
  logic       cause;
  logic       wr_dp;
  logic [3:0] since_low;
  logic [9:0] since_cause;
  logic [3:0] b1_run;
  logic [3:0] quiet;

  // Accepted transfer, and any pin that may ask for system reset
  assign acc   = hsel && hready && htrans[1];
  assign cause = !power_button_one || !power_button_two || !power_button_three
                 || !watchdog_input;

  // Saturating counts, so long waits need no unrolled repetition
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wr_dp       <= 1'b0;
      since_low   <= 4'hf;
      since_cause <= 10'h3ff;
      b1_run      <= 4'h0;
      quiet       <= 4'h0;
    end else begin
      wr_dp       <= acc && hwrite;
      since_low   <= !system_reset_n ? 4'h0 : since_low + {3'h0, since_low != 4'hf};
      since_cause <= cause ? 10'h000 : since_cause + {9'h0, since_cause != 10'h3ff};
      b1_run      <= power_button_one ? 4'h0 : b1_run + {3'h0, b1_run != 4'hf};
      quiet       <= ((acc && hwrite) || $changed(standby_in)
                      || $changed(secondary_standby_in)) ? 4'h0
                     : quiet + {3'h0, quiet != 4'hf};
    end
  end

  // -----------------------------------------------------------------
  // Properties
  // -----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_okay_resp: assert property (hresp == 1'b0)
    else $error("slave gave an error response");
  a_read_wait: assert property (acc && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not exactly one wait state");
  a_write_nowait: assert property (acc && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  a_top_zero: assert property (hrdata[31:24] == 8'h00)
    else $error("read data above bit 23 not zero");
  a_cut_write: assert property ($changed({power_cut_limit, power_cut_count,
    power_cut_timer}) |-> $past(wr_dp) || $past(wr_dp, 2))
    else $error("power-cut fields moved without a write");
  a_pup_pulse: assert property (power_up_request |=> !power_up_request)
    else $error("power-up request longer than one cycle");
  a_pup_cause: assert property (power_up_request |-> since_low <= 4'ha)
    else $error("power-up request without a recent system reset");
  a_rst_cause: assert property ($rose(system_reset_request) |-> since_cause <= 10'h320)
    else $error("reset request with no button or watchdog cause");
  a_bounce_min: assert property ($rose(button_pressed[0]) |-> b1_run >= 4'h3)
    else $error("button one seen pressed too early");
  a_stby_quiet: assert property (quiet == 4'hf |-> $stable(standby_active)
    && $stable(secondary_standby_active))
    else $error("standby output moved with inputs and setting quiet");

  // Main scenarios reached
  c_read: cover property (acc && !hwrite);
  c_pup: cover property (power_up_request);
  c_rst: cover property ($rose(system_reset_request));
endmodule : pcbr_regs_asserts

// File: tb/pcbr_regs_tb_top.sv
/*
  Self-checking bench for the power-control register bank.
  Drives AHB-Lite and all pins itself; debounce counts shortened for simulation.
*/
module pcbr_regs_tb_top
  import pcbr_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  // -----------------------------------------------------------------
  // Stimulus, tables and design
  // -----------------------------------------------------------------
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic        system_reset_n = 1'b1;
  logic        watchdog_input = 1'b1;
  logic        power_button_one = 1'b1;
  logic        power_button_two = 1'b1;
  logic        power_button_three = 1'b1;
  logic        standby_in = 1'b1;
  logic        secondary_standby_in = 1'b0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, system_reset_request, power_up_request;
  logic        standby_active, secondary_standby_active, global_reset_active;
  logic [2:0]  button_pressed;
  logic [1:0]  standby_delay_sel;
  logic [7:0]  power_cut_timer;
  logic [3:0]  power_cut_count, power_cut_limit;
  int          bad_count = 0;
  int          total_checks = 0;
  int          hits;
  // Last entry 0x30 is an unmapped index
  logic [7:0]  idx_tab [9] = '{IDX_POWER_CUT_LIMITS, IDX_RESET_SOURCE_CONTROL,
    IDX_UNUSED_SIXTEEN, IDX_UNUSED_SEVENTEEN, IDX_BACKUP_WORD_A, IDX_BACKUP_WORD_B,
    IDX_RTC_TIME_WORD, IDX_GLOBAL_RESET_CONTROL, 8'h30};
  logic [23:0] rst_tab [9] = '{24'h0, 24'h400000, 24'h0, 24'h0, 24'h0, 24'h0,
    24'h0, 24'h0, 24'h0};
  logic [23:0] one_tab [9] = '{24'h00ffff, 24'hc67fff, 24'h0, 24'h0, 24'hffffff,
    24'hffffff, 24'h3fffff, 24'h000001, 24'h0};

  always #2 ref_clk = ~ref_clk;

  pcbr_regs #(.DEBOUNCE_US_0(0), .DEBOUNCE_US_1(1), .DEBOUNCE_US_2(2),
              .DEBOUNCE_US_3(3)) u_dut (
    .ref_clk, .reset, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .system_reset_n,
    .power_button_one, .power_button_two, .power_button_three, .standby_in,
    .secondary_standby_in, .watchdog_input, .system_reset_request, .power_up_request,
    .standby_active, .secondary_standby_active, .global_reset_active, .button_pressed,
    .standby_delay_sel, .power_cut_timer, .power_cut_count, .power_cut_limit);

  // -----------------------------------------------------------------
  // Bus and checking tasks
  // -----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  // Ready is read before the edge, so the design's own update cannot race it
  task automatic phase(output logic [31:0] rd);
    logic ok;
    ok = 1'b0;
    while (ok !== 1'b1) begin
      @(negedge ref_clk);
      ok = hreadyout;
      rd = hrdata;
      @(posedge ref_clk);
    end
  endtask : phase

  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge ref_clk);
    htrans <= 2'h2;
    haddr  <= {22'h0, idx, 2'h0};
    hwrite <= wr;
    phase(rd);
    htrans <= 2'h0;
    hwdata <= wd;
    phase(rd);
  endtask : xfer

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, idx, d, r);
  endtask : wr

  task automatic rd_chk(input logic [7:0] idx, input logic [23:0] exp);
    logic [31:0] r;
    xfer(1'b0, idx, 32'h0, r);
    chk(r, {8'h0, exp});
  endtask : rd_chk

  // Let pin changes settle, then look between edges
  task automatic look(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : look

  task automatic close_out();
    if (bad_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      rd_chk(idx_tab[i], rst_tab[i]);
    end
    for (int i = 0; i < 9; i++) begin
      wr(idx_tab[i], 32'hffffffff);
      rd_chk(idx_tab[i], one_tab[i]);
    end
    look(8);
    chk(32'({standby_active, secondary_standby_active}), 32'h1);
    chk(32'(global_reset_active), 32'h1);
    chk(32'(standby_delay_sel), 32'h3);
    wr(IDX_POWER_CUT_LIMITS, 32'h0012a5c3);
    rd_chk(IDX_POWER_CUT_LIMITS, 24'h00a5c3);
    wr(IDX_RESET_SOURCE_CONTROL, 32'h00000002);
    wr(IDX_GLOBAL_RESET_CONTROL, 32'h0);
    power_button_two <= 1'b0;
    look(20);
    chk({16'h0, power_cut_limit, power_cut_count, power_cut_timer}, 32'ha5c3);
    chk(32'({standby_active, secondary_standby_active}), 32'h2);
    chk(32'(global_reset_active), 32'h0);
    chk(32'({button_pressed, system_reset_request}), 32'h4);
    @(posedge ref_clk);
    power_button_one <= 1'b0;
    look(20);
    chk(32'({button_pressed, system_reset_request}), 32'h7);
    @(posedge ref_clk);
    power_button_one <= 1'b1;
    power_button_two <= 1'b1;
    look(20);
    chk(32'(system_reset_request), 32'h0);
    // Button three resets and drives global reset; standby pins flip level
    wr(IDX_RESET_SOURCE_CONTROL, 32'h00000008);
    power_button_three   <= 1'b0;
    standby_in           <= 1'b0;
    secondary_standby_in <= 1'b1;
    look(20);
    chk(32'({global_reset_active, button_pressed, system_reset_request}), 32'h19);
    chk(32'({standby_active, secondary_standby_active}), 32'h1);
    @(posedge ref_clk);
    power_button_three <= 1'b1;
    look(20);
    chk(32'({global_reset_active, system_reset_request}), 32'h0);
    // Slowest debounce choice: 750 cycles before the press counts
    wr(IDX_RESET_SOURCE_CONTROL, 32'h00000032);
    power_button_one <= 1'b0;
    look(300);
    chk(32'(system_reset_request), 32'h0);
    look(500);
    chk(32'(system_reset_request), 32'h1);
    @(posedge ref_clk);
    power_button_one <= 1'b1;
    look(800);
    wr(IDX_RESET_SOURCE_CONTROL, 32'h00001001);
    wr(IDX_BACKUP_WORD_A, 32'h00abcdef);
    watchdog_input <= 1'b0;
    look(20);
    chk(32'(system_reset_request), 32'h1);
    @(posedge ref_clk);
    watchdog_input <= 1'b1;
    system_reset_n <= 1'b0;
    look(10);
    rd_chk(IDX_RESET_SOURCE_CONTROL, 24'h400001);
    system_reset_n <= 1'b1;
    hits = 0;
    repeat (20) begin
      @(negedge ref_clk);
      hits += int'(power_up_request === 1'b1);
    end
    chk(32'(hits), 32'h1);
    chk(32'(standby_delay_sel), 32'h1);
    rd_chk(IDX_BACKUP_WORD_A, 24'habcdef);
    watchdog_input <= 1'b0;
    look(20);
    chk(32'(system_reset_request), 32'h0);
    @(posedge ref_clk);
    watchdog_input <= 1'b1;
    reset <= 1'b1;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    rd_chk(IDX_BACKUP_WORD_A, 24'h0);
    close_out();
  end

  // Whole run is about 2000 cycles; a hang is cut off well beyond that
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    close_out();
  end
endmodule : pcbr_regs_tb_top

bind pcbr_regs pcbr_regs_asserts u_chk (.ref_clk, .reset, .hsel, .hwrite, .hready,
  .hreadyout, .hresp, .htrans, .hrdata, .system_reset_n, .watchdog_input,
  .power_up_request, .power_button_one, .power_button_two, .power_button_three,
  .standby_in, .secondary_standby_in, .system_reset_request, .standby_active,
  .secondary_standby_active, .button_pressed, .power_cut_timer, .power_cut_count,
  .power_cut_limit);
